// ===== logic/cmsl_defines.svh
`ifndef CMSL_DEFINES_SVH
`define CMSL_DEFINES_SVH
// Bank layout offsets.
`define CMSL_CORE_LAST      7'h0b
`define CMSL_SFR_LAST       7'h1f
`define CMSL_GPR_FIRST      7'h20
`define CMSL_GPR_LAST       7'h6f
`define CMSL_COMMON_FIRST   7'h70
`define CMSL_GPR_BYTES      8'h50
// Core register offsets within each bank.
`define CMSL_OFF_IND0       7'h00
`define CMSL_OFF_IND1       7'h01
`define CMSL_OFF_STATUS     7'h03
`define CMSL_OFF_PTR0L      7'h04
`define CMSL_OFF_PTR0H      7'h05
`define CMSL_OFF_PTR1L      7'h06
`define CMSL_OFF_PTR1H      7'h07
`define CMSL_OFF_BANKSEL    7'h08
// Status register bit positions.
`define CMSL_ST_WDT_N       4
`define CMSL_ST_PD_N        3
`define CMSL_ST_ZERO        2
`define CMSL_ST_DC          1
`define CMSL_ST_CARRY       0
`define CMSL_ST_RESET       8'h18
// Pointer high bit 7 selects program memory.
`define CMSL_PTR_PROG_BIT   15
// Linear window base in pointer space and its size.
`define CMSL_LIN_BASE       16'h2000
`define CMSL_LIN_WORDS      12'ha00
// Implemented program memory: last word.
`define CMSL_PROG_LAST      15'h07ff
`define CMSL_PROG_AW        11
// Stack.
`define CMSL_STACK_DEPTH    16
`define CMSL_STACK_AW       4
`define CMSL_STACK_TOP      4'hf
`endif

// ===== logic/cmsl_pkg.sv
package cmsl_pkg;
    // Memory request from the core's execution unit.
    typedef struct packed {
        logic        rd;     // Read strobe.
        logic        wr;     // Write strobe.
        logic        ind;    // Access uses indirect pointer.
        logic        sel;    // Which pointer.
        logic [6:0]  off;    // Bank offset for direct access.
        logic [7:0]  wdata;  // Write data.
    } cmsl_mem_req_t;
    // ALU outcome for status flags.
    typedef struct packed {
        logic       upd_z;   // Updates zero flag.
        logic       upd_dc;  // Updates nibble carry.
        logic       upd_c;   // Updates carry.
        logic       z;       // Result zero.
        logic       dc;      // Carry out of bit 3.
        logic       c;       // Carry out of bit 7.
    } cmsl_alu_flags_t;
    typedef enum logic [2:0] {
        CMSL_IDLE  = 3'b001,
        CMSL_FETCH = 3'b010,
        CMSL_DONE  = 3'b100
    } cmsl_pstate_t;
endpackage : cmsl_pkg

// ===== logic/cmsl_ret_stack.sv
`timescale 1ns/10ps
`include "cmsl_defines.svh"
module cmsl_ret_stack (
    input  wire logic        clk_sys_i,  // Core clock.
    input  wire logic        rst_n_i,    // Synchronous reset, active low.
    input  wire logic        push_i,     // Call: push return address.
    input  wire logic        pop_i,      // Return: pop address.
    input  wire logic [14:0] addr_i,     // Address to push.
    output logic      [14:0] top_o,      // Last pushed address.
    output logic             ovf_o,      // Pulse: push onto full stack.
    output logic             unf_o       // Pulse: pop from empty stack.
);
    logic [14:0] mem_reg [`CMSL_STACK_DEPTH];
    logic [`CMSL_STACK_AW-1:0] ptr_reg;
    logic                      full_reg;
    logic                      empty_reg;

    // Sixteen 15-bit entries kept apart from data memory.
    always_ff @(posedge clk_sys_i) begin
        if (push_i && !full_reg) begin
            mem_reg[empty_reg ? ptr_reg : ptr_reg + 4'h1] <= addr_i;
        end
    end

    // Pointer at the top entry; empty and full are tracked apart.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ptr_reg   <= 4'h0;
            empty_reg <= 1'b1;
            full_reg  <= 1'b0;
        end else if (push_i && !full_reg) begin
            if (!empty_reg) begin
                ptr_reg <= ptr_reg + 4'h1;
            end
            empty_reg <= 1'b0;
            full_reg  <= !empty_reg && (ptr_reg == `CMSL_STACK_TOP - 4'h1);
        end else if (pop_i && !empty_reg) begin
            if (ptr_reg == 4'h0) begin
                empty_reg <= 1'b1;
            end else begin
                ptr_reg <= ptr_reg - 4'h1;
            end
            full_reg <= 1'b0;
        end
    end

    // Error pulses, registered; the top word is registered too.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ovf_o <= 1'b0;
            unf_o <= 1'b0;
            top_o <= 15'h0000;
        end else begin
            ovf_o <= push_i && full_reg;
            unf_o <= pop_i && empty_reg;
            top_o <= empty_reg ? 15'h0000 : mem_reg[ptr_reg];
        end
    end
endmodule : cmsl_ret_stack

// ===== logic/cmsl_core_mem.sv
`timescale 1ns/10ps
`include "cmsl_defines.svh"
// Overview of operation
// - Sixteen-entry, fifteen-bit return stack separate from data memory.
// - Stack overflow/underflow sets its flag; optional software reset follows.
// - Two 16-bit pointers reach all file registers and program memory.
// - Indirect access to program memory costs one extra cycle.
// - Pointers give a linear non-banked view of general RAM.
// - Program counter is fifteen bits, 32K word space.
// - Program addresses past the last word wrap into implemented space.
// - Pointer high bit 7 set makes indirect reads hit program memory.
// - Indirect load from program memory returns the low eight bits.
// - Indirect writes to program memory are ignored.
// - Data memory is 32 banks of 128 bytes, partitioned per bank.
// - First twelve addresses of each bank are the shared core registers.
// - Direct addressing uses the bank last written to the bank selector.
// - Unimplemented data memory reads as zero.
// - Flag-updating writes to status keep ALU flags, not the result.
// - Software cannot write the watchdog and power-down flags.
// - Status bits 7 to 5 always read zero.
// - Watchdog flag set on power-up, clear or sleep; cleared on timeout.
// - Power-down flag set on power-up or clear; cleared by sleep.
// - Zero flag follows whether the ALU result is zero.
// - Nibble carry flag follows carry out of bit 3.
// - Carry flag follows carry out of bit 7; inverted borrow on subtract.
module cmsl_core_mem (
    input  wire logic                   clk_sys_i,     // Core clock.
    input  wire logic                   rst_n_i,       // Synchronous reset, active low.
    input  wire logic                   por_i,         // Power-up reset pulse.
    input  wire cmsl_pkg::cmsl_mem_req_t req_i,        // Data memory request.
    input  wire cmsl_pkg::cmsl_alu_flags_t alu_i,      // ALU outcome.
    input  wire logic                   wdt_clear_i,   // Watchdog clear executed.
    input  wire logic                   sleep_i,       // Sleep executed.
    input  wire logic                   wdt_timeout_i, // Watchdog timed out.
    input  wire logic                   push_i,        // Call pushes.
    input  wire logic                   pop_i,         // Return pops.
    input  wire logic [14:0]            pc_i,          // Program counter to push.
    input  wire logic                   stk_rst_en_i,  // Stack error reset option.
    input  wire logic                   ovf_clr_i,     // Software clears overflow flag.
    input  wire logic                   unf_clr_i,     // Software clears underflow flag.
    input  wire logic [13:0]            prog_data_i,   // Program word read back.
    output logic      [14:0]            prog_addr_o,   // Program address, wrapped.
    output logic                        prog_rd_o,     // Program read strobe.
    output logic      [7:0]             rdata_o,       // Read data.
    output logic                        rvalid_o,      // Read data valid pulse.
    output logic                        stall_o,       // Extra cycle for program read.
    output logic      [14:0]            stack_top_o,   // Return address.
    output logic      [7:0]             status_o,      // Status register.
    output logic      [4:0]             bank_o,        // Active bank.
    output logic                        stack_ovf_o,   // Overflow flag.
    output logic                        stack_unf_o,   // Underflow flag.
    output logic                        soft_rst_o     // Software reset pulse.
);
    // General RAM per bank and the shared common RAM.
    logic [7:0]  gpr_mem [32][80];
    logic [7:0]  common_mem [16];
    logic [15:0] ptr_reg [2];
    logic [4:0]  bank_reg;
    logic [7:0]  status_reg;
    // Sticky stack errors and the raw pulses.
    logic        ovf_reg;
    logic        unf_reg;
    logic        ovf_p;
    logic        unf_p;
    cmsl_pkg::cmsl_pstate_t pstate_reg;
    // Decode of the request in flight.
    logic [15:0] cur_ptr;
    logic        ind_prog;
    logic [4:0]  eff_bank;
    logic [6:0]  eff_off;
    logic        gpr_hit;
    logic [6:0]  gpr_idx;
    logic [7:0]  rdata_next;

    // Wrap any program address into the implemented words.
    // Only the low eleven bits reach the array,
    // so a far address folds back to the start.
    // A mask does it, with no compare to a limit.
    // Pure logic; nothing is stored here.
    function automatic logic [14:0] cmsl_wrap(input logic [14:0] a);
        return a & `CMSL_PROG_LAST;
    endfunction : cmsl_wrap

    // Split a pointer value into bank and offset, linear window included.
    // Outside the window the pointer is a plain
    // bank and offset pair, which keeps the core
    // slots and common RAM reachable through it.
    // Inside it the general RAM of all banks lies
    // end to end, 80 bytes each, so a buffer may
    // cross a bank boundary without a break.
    function automatic logic [11:0] cmsl_decode(input logic [15:0] p);
        logic [11:0] lin;
        logic [11:0] q;
        lin = p[11:0];
        q   = 12'h000;
        if (p[15:12] == 4'h2 && lin < `CMSL_LIN_WORDS) begin
            // Linear view: 80 bytes per bank, back to back.
            q[11:7] = 5'(lin / 12'(`CMSL_GPR_BYTES));
            q[6:0]  = 7'(lin % 12'(`CMSL_GPR_BYTES)) + `CMSL_GPR_FIRST;
        end else begin
            q = p[11:0];
        end
        return q;
    endfunction : cmsl_decode

    // Return stack: calls push the program
    // counter and returns pop it. A push onto a
    // full stack or a pop from an empty one is
    // refused and reported as a one-cycle pulse.
    cmsl_ret_stack u_stack (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .push_i    (push_i),
        .pop_i     (pop_i),
        .addr_i    (pc_i),
        .top_o     (stack_top_o),
        .ovf_o     (ovf_p),
        .unf_o     (unf_p)
    );

    // Address path: pointer or bank selector plus offset.
    // An indirect access takes bank and offset
    // from the selected pointer, a direct one
    // from the bank selector and its offset.
    // The program memory flag is decided once
    // here and gates every write below.
    always_comb begin
        cur_ptr  = ptr_reg[req_i.sel];
        ind_prog = req_i.ind && cur_ptr[`CMSL_PTR_PROG_BIT];
        if (req_i.ind) begin
            {eff_bank, eff_off} = cmsl_decode(cur_ptr);
        end else begin
            {eff_bank, eff_off} = {bank_reg, req_i.off};
        end
        gpr_hit = eff_off >= `CMSL_GPR_FIRST && eff_off <= `CMSL_GPR_LAST;
        gpr_idx = eff_off - `CMSL_GPR_FIRST;
    end

    // Program path: the read is issued from the pointer, low 15 bits wrapped.
    // The strobe only rises from idle, so a
    // program read that arrives while the
    // sequencer is busy is dropped; software
    // spaces program reads three cycles apart.
    assign prog_addr_o = cmsl_wrap(cur_ptr[14:0]);
    assign prog_rd_o   = req_i.rd && ind_prog && (pstate_reg == cmsl_pkg::CMSL_IDLE);
    assign stall_o     = prog_rd_o;

    // Extra cycle sequencer for program memory reads.
    // Idle takes the request, fetch samples the
    // word the array returns a cycle after the
    // strobe, and done holds off a new request.
    // That extra cycle stretches the instruction.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pstate_reg <= cmsl_pkg::CMSL_IDLE;
        end else begin
            unique case (pstate_reg)
                cmsl_pkg::CMSL_IDLE:  pstate_reg <= prog_rd_o ? cmsl_pkg::CMSL_FETCH
                                                              : cmsl_pkg::CMSL_IDLE;
                cmsl_pkg::CMSL_FETCH: pstate_reg <= cmsl_pkg::CMSL_DONE;
                cmsl_pkg::CMSL_DONE:  pstate_reg <= cmsl_pkg::CMSL_IDLE;
            endcase
        end
    end

    // Data read mux: core registers are shared across banks.
    // The core slots are decoded before the bank
    // is looked at, so they sit at the same place
    // in every bank. Empty slots and the whole
    // peripheral range read as zero, so no stale
    // value leaks onto the read bus.
    always_comb begin
        rdata_next = 8'h00;
        if (eff_off <= `CMSL_CORE_LAST) begin
            unique case (eff_off)
                `CMSL_OFF_STATUS:  rdata_next = status_reg;
                `CMSL_OFF_PTR0L:   rdata_next = ptr_reg[0][7:0];
                `CMSL_OFF_PTR0H:   rdata_next = ptr_reg[0][15:8];
                `CMSL_OFF_PTR1L:   rdata_next = ptr_reg[1][7:0];
                `CMSL_OFF_PTR1H:   rdata_next = ptr_reg[1][15:8];
                `CMSL_OFF_BANKSEL: rdata_next = {3'h0, bank_reg};
                default:           rdata_next = 8'h00;
            endcase
        end else if (gpr_hit) begin
            rdata_next = gpr_mem[eff_bank][gpr_idx];
        end else if (eff_off >= `CMSL_COMMON_FIRST) begin
            rdata_next = common_mem[eff_off[3:0]];
        end
    end

    // Read answer: data memory next cycle, program word after the extra cycle.
    // Only the low byte of the fourteen-bit
    // program word comes back on this path.
    // A data read that lands in the fetch cycle
    // loses to the program byte.
    // A program read's valid lasts one cycle; a data read's lasts as long as its request is held.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rdata_o  <= 8'h00;
            rvalid_o <= 1'b0;
        end else if (pstate_reg == cmsl_pkg::CMSL_FETCH) begin
            rdata_o  <= prog_data_i[7:0];
            rvalid_o <= 1'b1;
        end else begin
            rdata_o  <= rdata_next;
            rvalid_o <= req_i.rd && !ind_prog;
        end
    end

    // RAM writes; indirect writes aimed at program memory are dropped.
    // The RAM has no reset: its contents are
    // undefined after power-up, so software must
    // write a location before reading it back.
    // Core and peripheral slots never touch it.
    always_ff @(posedge clk_sys_i) begin
        if (req_i.wr && !ind_prog) begin
            if (gpr_hit) begin
                gpr_mem[eff_bank][gpr_idx] <= req_i.wdata;
            end else if (eff_off >= `CMSL_COMMON_FIRST) begin
                common_mem[eff_off[3:0]] <= req_i.wdata;
            end
        end
    end

    // Pointers and bank selector, written through their core slots.
    // Each pointer byte is its own slot, so a
    // pointer takes two writes; an access made
    // between them sees a half-loaded pointer.
    // A bank write keeps only its low five bits.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ptr_reg[0] <= 16'h0000;
            ptr_reg[1] <= 16'h0000;
            bank_reg   <= 5'h00;
        end else if (req_i.wr && !ind_prog) begin
            unique case (eff_off)
                `CMSL_OFF_PTR0L:   ptr_reg[0][7:0]  <= req_i.wdata;
                `CMSL_OFF_PTR0H:   ptr_reg[0][15:8] <= req_i.wdata;
                `CMSL_OFF_PTR1L:   ptr_reg[1][7:0]  <= req_i.wdata;
                `CMSL_OFF_PTR1H:   ptr_reg[1][15:8] <= req_i.wdata;
                `CMSL_OFF_BANKSEL: bank_reg <= req_i.wdata[4:0];
                default:           bank_reg <= bank_reg;
            endcase
        end
    end

    // Status register; ALU flags win over a write to the same bits.
    // Bits 4 and 3 follow hardware events only.
    // A setting event beats a clearing one in
    // the same cycle, so a watchdog clear and a
    // time-out together leave the flag set.
    // The three top bits are forced to zero.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            status_reg <= `CMSL_ST_RESET;
        end else begin
            if (req_i.wr && !ind_prog && eff_off == `CMSL_OFF_STATUS
                    && !(alu_i.upd_z || alu_i.upd_dc || alu_i.upd_c)) begin
                // Only the three arithmetic bits take software data.
                // A flag-updating instruction blocks all three.
                status_reg[2:0] <= req_i.wdata[2:0];
            end
            if (alu_i.upd_z) status_reg[`CMSL_ST_ZERO]  <= alu_i.z;
            if (alu_i.upd_dc) status_reg[`CMSL_ST_DC]   <= alu_i.dc;
            if (alu_i.upd_c) status_reg[`CMSL_ST_CARRY] <= alu_i.c;
            if (por_i || wdt_clear_i || sleep_i) begin
                status_reg[`CMSL_ST_WDT_N] <= 1'b1;
            end else if (wdt_timeout_i) begin
                status_reg[`CMSL_ST_WDT_N] <= 1'b0;
            end
            if (por_i || wdt_clear_i) begin
                status_reg[`CMSL_ST_PD_N] <= 1'b1;
            end else if (sleep_i) begin
                status_reg[`CMSL_ST_PD_N] <= 1'b0;
            end
            status_reg[7:5] <= 3'h0;
        end
    end

    // Sticky stack error flags; a new event beats a clear.
    // The flags stay up until software clears
    // them, so a short burst is never missed.
    // The reset pulse lasts one cycle and only
    // leaves when the reset option is enabled.
    // Clearing a flag has no effect on the stack.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ovf_reg    <= 1'b0;
            unf_reg    <= 1'b0;
            soft_rst_o <= 1'b0;
        end else begin
            ovf_reg    <= ovf_p | (ovf_reg & ~ovf_clr_i);
            unf_reg    <= unf_p | (unf_reg & ~unf_clr_i);
            soft_rst_o <= stk_rst_en_i & (ovf_p | unf_p);
        end
    end

    // Registered state straight to the ports.
    assign status_o    = status_reg;
    assign bank_o      = bank_reg;
    assign stack_ovf_o = ovf_reg;
    assign stack_unf_o = unf_reg;
endmodule : cmsl_core_mem

// ===== tb/cmsl_core_mem_monitor.sv
`timescale 1ns/10ps
module cmsl_core_mem_monitor (
    input wire logic                      clk_sys_i,     // Core clock.
    input wire logic                      rst_n_i,       // Synchronous reset, active low.
    input wire logic                      por_i,         // Power-up pulse.
    input wire cmsl_pkg::cmsl_mem_req_t   req_i,         // Memory request.
    input wire cmsl_pkg::cmsl_alu_flags_t alu_i,         // ALU outcome.
    input wire logic                      wdt_clear_i,   // Watchdog clear.
    input wire logic                      sleep_i,       // Sleep executed.
    input wire logic                      wdt_timeout_i, // Watchdog time-out.
    input wire logic [13:0]               prog_data_i,   // Program word.
    input wire logic [14:0]               prog_addr_o,   // Program address.
    input wire logic                      prog_rd_o,     // Program read strobe.
    input wire logic [7:0]                rdata_o,       // Read data.
    input wire logic                      rvalid_o,      // Read valid.
    input wire logic                      stall_o,       // Extra cycle.
    input wire logic [7:0]                status_o,      // Status register.
    input wire logic                      stack_ovf_o,   // Overflow flag.
    input wire logic                      stack_unf_o,   // Underflow flag.
    input wire logic                      soft_rst_o     // Software reset pulse.
);
    // Every check runs on the core clock and sleeps through reset.
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    property p_stall; stall_o == prog_rd_o; endproperty
    a_stall: assert property (p_stall) else $error("stall differs from program read");
    property p_wrap; prog_rd_o |-> prog_addr_o[14:11] == 4'h0; endproperty
    a_wrap: assert property (p_wrap) else $error("program address not wrapped");
    property p_byte; prog_rd_o |-> ##2 rvalid_o && rdata_o == $past(prog_data_i[7:0]); endproperty
    a_byte: assert property (p_byte) else $error("program read byte wrong");
    property p_data_rd; req_i.rd && !prog_rd_o && !$past(prog_rd_o) && !$past(prog_rd_o, 2)
        |=> rvalid_o; endproperty
    a_data_rd: assert property (p_data_rd) else $error("data read not answered");
    property p_top_zero; status_o[7:5] == 3'h0; endproperty
    a_top_zero: assert property (p_top_zero) else $error("status top bits set");
    property p_sleep; sleep_i && !(por_i || wdt_clear_i || wdt_timeout_i)
        |=> status_o[4:3] == 2'b10; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
    property p_timeout; wdt_timeout_i && !(por_i || wdt_clear_i || sleep_i)
        |=> !status_o[4]; endproperty
    a_timeout: assert property (p_timeout) else $error("time-out flag wrong");
    property p_hw_bits; !(por_i || wdt_clear_i || sleep_i || wdt_timeout_i)
        |=> $stable(status_o[4:3]); endproperty
    a_hw_bits: assert property (p_hw_bits) else $error("hardware flags moved");
    property p_zero; alu_i.upd_z |=> status_o[2] == $past(alu_i.z); endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");
    property p_carry; alu_i.upd_dc && alu_i.upd_c
        |=> status_o[1:0] == $past({alu_i.dc, alu_i.c}); endproperty
    a_carry: assert property (p_carry) else $error("carry flags wrong");
    property p_soft_rst; soft_rst_o |-> stack_ovf_o || stack_unf_o; endproperty
    a_soft_rst: assert property (p_soft_rst) else $error("reset without stack error");
endmodule : cmsl_core_mem_monitor

bind cmsl_core_mem cmsl_core_mem_monitor mon_u (.clk_sys_i, .rst_n_i, .por_i, .req_i, .alu_i,
    .wdt_clear_i, .sleep_i, .wdt_timeout_i, .prog_data_i, .prog_addr_o, .prog_rd_o, .rdata_o,
    .rvalid_o, .stall_o, .status_o, .stack_ovf_o, .stack_unf_o, .soft_rst_o);

// ===== tb/cmsl_core_mem_tb_top.sv
`timescale 1ns/10ps
module cmsl_core_mem_tb_top;
    logic                      clk_sys_i = 1'b0, rst_n_i = 1'b0, stk_rst_en_i = 1'b1;
    logic                      por_i = 0, wdt_clear_i = 0, sleep_i = 0, wdt_timeout_i = 0;
    logic                      push_i = 0, pop_i = 0, ovf_clr_i = 0, unf_clr_i = 0;
    logic                      prog_rd_o, rvalid_o, stall_o, stack_ovf_o, stack_unf_o, soft_rst_o;
    logic [14:0]               pc_i = 15'h0, prog_addr_o, stack_top_o, pa;
    logic [13:0]               prog_data_i = 14'h0;
    logic [7:0]                rdata_o, status_o, rv;
    logic [4:0]                bank_o;
    cmsl_pkg::cmsl_mem_req_t   req_i = '0;
    cmsl_pkg::cmsl_alu_flags_t alu_i = '0;
    int                        fail_count = 0, checks = 0, lat;

    cmsl_core_mem dut_u (.clk_sys_i, .rst_n_i, .por_i, .req_i, .alu_i, .wdt_clear_i, .sleep_i,
        .wdt_timeout_i, .push_i, .pop_i, .pc_i, .stk_rst_en_i, .ovf_clr_i, .unf_clr_i,
        .prog_data_i, .prog_addr_o, .prog_rd_o, .rdata_o, .rvalid_o, .stall_o, .stack_top_o,
        .status_o, .bank_o, .stack_ovf_o, .stack_unf_o, .soft_rst_o);

    // Free-running core clock, 4 ns period.
    always #2 clk_sys_i = ~clk_sys_i;

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One request held for a single edge; the wait counts extra cycles a read costs.
    task automatic acc(input logic rd, ind, sel, input logic [6:0] off, input logic [7:0] wd);
        @(posedge clk_sys_i);
        req_i <= '{rd, !rd, ind, sel, off, wd};
        #1 pa = prog_addr_o;
        @(posedge clk_sys_i);
        req_i <= '0;
        lat = 0;
        #1;
        while (rd && !rvalid_o && lat < 4) begin
            @(posedge clk_sys_i);
            #1 lat++;
        end
        rv = rdata_o;
    endtask : acc

    // Pulses the event strobes for one edge, then lets that edge's update land.
    task automatic ev(input logic [7:0] m, input logic [14:0] p);
        @(posedge clk_sys_i);
        {por_i, wdt_clear_i, sleep_i, wdt_timeout_i, push_i, pop_i, ovf_clr_i, unf_clr_i} <= m;
        pc_i <= p;
        @(posedge clk_sys_i);
        {por_i, wdt_clear_i, sleep_i, wdt_timeout_i, push_i, pop_i, ovf_clr_i, unf_clr_i} <= 0;
        #1;
    endtask : ev

    // ALU flag update, optionally racing a status write that must lose.
    task automatic alu(input logic [2:0] f, input logic w);
        @(posedge clk_sys_i);
        alu_i <= '{1'b1, 1'b1, 1'b1, f[2], f[1], f[0]};
        if (w) req_i <= '{1'b0, 1'b1, 1'b0, 1'b0, 7'h03, 8'h00};
        @(posedge clk_sys_i);
        alu_i <= '0;
        req_i <= '0;
        #1;
    endtask : alu

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    // Main sequence: status, banking, pointers, program reads, stack.
    initial begin
        repeat (8) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        ev(8'h80, 15'h0);
        acc(1, 0, 0, 7'h03, 8'h00); chk(16'(rv), 16'h18);
        acc(0, 0, 0, 7'h03, 8'hff); chk(16'(status_o), 16'h1f);
        acc(0, 0, 0, 7'h03, 8'h00); chk(16'(status_o), 16'h18);
        for (int i = 0; i < 8; i++) begin
            alu(i[2:0], i[0]); chk(16'(status_o), 16'h18 | 16'(i));
        end
        ev(8'h20, 15'h0); chk(16'(status_o), 16'h17);
        ev(8'h10, 15'h0); chk(16'(status_o), 16'h07);
        ev(8'h40, 15'h0); chk(16'(status_o), 16'h1f);
        $display("test status done");
        acc(0, 0, 0, 7'h08, 8'h05); chk(16'(bank_o), 16'h05);
        acc(0, 0, 0, 7'h70, 8'h3c);
        acc(0, 0, 0, 7'h20, 8'ha5);
        acc(0, 0, 0, 7'h08, 8'h1f); chk(16'(bank_o), 16'h1f);
        acc(1, 0, 0, 7'h70, 8'h00); chk(16'(rv), 16'h3c);
        acc(1, 0, 0, 7'h03, 8'h00); chk(16'(rv), 16'h1f);
        acc(1, 0, 0, 7'h09, 8'h00); chk(16'(rv), 16'h00);
        $display("test banking done");
        // Pointer 1 at linear 0x2190 lands on bank 5 offset 0x20.
        acc(0, 0, 0, 7'h06, 8'h90);
        acc(0, 0, 0, 7'h07, 8'h21);
        acc(1, 1, 1, 7'h00, 8'h00); chk(16'(rv), 16'ha5);
        chk(16'(lat), 16'h0);
        acc(0, 1, 1, 7'h00, 8'h66);
        acc(0, 0, 0, 7'h08, 8'h05);
        acc(1, 0, 0, 7'h20, 8'h00); chk(16'(rv), 16'h66);
        // Pointer 0 at 0xf2a0 reads program word 0x2a0 after the wrap; as data
        // it would hit bank 5 offset 0x20, so a write that slipped through shows.
        acc(0, 0, 0, 7'h04, 8'ha0);
        acc(0, 0, 0, 7'h05, 8'hf2);
        prog_data_i <= 14'h2abc;
        acc(1, 1, 0, 7'h00, 8'h00); chk(16'(rv), 16'hbc);
        chk(16'(pa), 16'h02a0);
        chk(16'(lat), 16'h1);
        acc(0, 1, 0, 7'h00, 8'h99);
        acc(1, 1, 1, 7'h00, 8'h00); chk(16'(rv), 16'h66);
        $display("test pointers done");
        for (int i = 0; i < 16; i++) begin
            // The top word shows one edge after the push lands.
            ev(8'h08, 15'h7ff0 + 15'(i));
            @(posedge clk_sys_i);
            #1 chk(16'(stack_top_o), 16'h7ff0 + 16'(i));
        end
        chk(16'(stack_ovf_o), 16'h0);
        ev(8'h08, 15'h1234);
        @(posedge clk_sys_i);
        #1 chk(16'({stack_ovf_o, soft_rst_o}), 16'h3);
        ev(8'h02, 15'h0); chk(16'(stack_ovf_o), 16'h0);
        for (int i = 15; i >= 0; i--) begin
            ev(8'h04, 15'h0);
            @(posedge clk_sys_i);
            #1 chk(16'(stack_top_o), i == 0 ? 16'h0 : 16'h7fef + 16'(i));
        end
        // Reset option off: the underflow must not reach the reset output.
        @(posedge clk_sys_i);
        stk_rst_en_i <= 1'b0;
        ev(8'h04, 15'h0);
        @(posedge clk_sys_i);
        #1 chk(16'({stack_unf_o, soft_rst_o}), 16'h2);
        ev(8'h01, 15'h0); chk(16'(stack_unf_o), 16'h0);
        $display("test stack done");
        end_sim();
    end

    // Cuts a hang short at about ten thousand cycles.
    initial begin
        #40000;
        fail_count++;
        end_sim();
    end
endmodule : cmsl_core_mem_tb_top
